// >>> rtl/chcfg_pkg.sv
// channel routing register bank: shared constants and types
// assumes a single 40 MHz clock and an axi4-lite register master
package chcfg_pkg;

   localparam int NUM_CH   = 16;
   localparam int CH_W     = 16;
   localparam int RES_MAX  = 24;
   localparam int STAT_W   = 8;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_STATUS   = 6'h00;
   localparam logic [5:0] IDX_CONTROL  = 6'h01;
   localparam logic [5:0] IDX_DATA     = 6'h02;
   localparam logic [5:0] IDX_CH_FIRST = 6'h09;
   localparam logic [5:0] IDX_CH_LAST  = 6'h18;
   localparam int         IDX_LSB      = 2;

   localparam logic [CH_W-1:0] CH0_RESET = 16'h8001;
   localparam logic [CH_W-1:0] CHN_RESET = 16'h0001;

   // control and status fields
   localparam int CTRL_APPEND_BIT  = 0;
   localparam int STATUS_FRESH_BIT = 7;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // input select codes
   localparam logic [4:0] SEL_PIN_LAST = 5'h0F;
   localparam logic [4:0] SEL_TEMP     = 5'h10;
   localparam logic [4:0] SEL_AVSS     = 5'h11;
   localparam logic [4:0] SEL_REF      = 5'h12;
   localparam logic [4:0] SEL_DREG_P   = 5'h1A;
   localparam logic [4:0] SEL_DREG_N   = 5'h1B;
   localparam logic [4:0] SEL_TEST_P   = 5'h1C;
   localparam logic [4:0] SEL_TEST_N   = 5'h1D;
   localparam logic [4:0] SEL_RSV_LO   = 5'h1E;

   typedef struct packed {
      logic       enable;
      logic [2:0] setup;
      logic [1:0] zero_pad;
      logic [4:0] positive_input_select;
      logic [4:0] negative_input_select;
   } chcfg_route_t;

   typedef enum logic [2:0] {
      SRC_PIN   = 3'b000,
      SRC_TEMP  = 3'b001,
      SRC_AVSS  = 3'b010,
      SRC_REF   = 3'b011,
      SRC_DREG  = 3'b100,
      SRC_TEST  = 3'b101,
      SRC_OTHER = 3'b110,
      SRC_RESV  = 3'b111
   } chcfg_src_t;

endpackage

// >>> rtl/chcfg_chan_reg.sv
// one 16-bit channel routing register with byte-lane writes
// assumes write enable is a one-cycle pulse from the bus slave
`timescale 1ns/10ps
module chcfg_chan_reg #(
   parameter logic [15:0] RESET_VALUE = 16'h0001
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // write side
   input  wire logic        wr_en,
   input  wire logic [1:0]  wr_strb,
   input  wire logic [15:0] wr_data,
   // stored value
   output logic      [15:0] value
);

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         value <= RESET_VALUE;
      end else if (wr_en) begin
         // each strobed byte kept as written, reserved bits too
         if (wr_strb[0]) begin
            value[7:0] <= wr_data[7:0];
         end
         if (wr_strb[1]) begin
            value[15:8] <= wr_data[15:8];
         end
      end
   end

endmodule

// >>> rtl/chcfg_top.sv
// channel routing register bank with sequencer and result status tagging
// assumes synchronous converter strobes and an axi4-lite master on clk_sys
`timescale 1ns/10ps
module chcfg_top #(
   parameter int RESULT_W = 24
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                arst_n,
   // axi4-lite write
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // converter side
   input  wire logic                conv_done,
   input  wire logic [RESULT_W-1:0] conv_result,
   output logic [3:0]               cur_channel,
   output logic [2:0]               cur_setup,
   output logic [4:0]               cur_pos_sel,
   output logic [4:0]               cur_neg_sel,
   output chcfg_pkg::chcfg_src_t    cur_pos_src,
   output chcfg_pkg::chcfg_src_t    cur_neg_src,
   output logic                     route_fault,
   output logic                     seq_active
);

   if (RESULT_W < 1 || RESULT_W > chcfg_pkg::RES_MAX) begin : g_chk
      $error("RESULT_W must lie between 1 and 24");
   end

   // reset release through two flops
   logic rst_meta;
   logic rst_n;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // checks share one clock and stay quiet while the internal reset holds
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   logic [chcfg_pkg::CH_W-1:0]   ch_q [chcfg_pkg::NUM_CH];
   chcfg_pkg::chcfg_route_t       cfg  [chcfg_pkg::NUM_CH];
   logic [chcfg_pkg::NUM_CH-1:0]  en;
   logic                          wr_fire;
   logic [5:0]                    wr_idx;
   logic [5:0]                    rd_idx;
   logic [31:0]                   wdata_q;
   logic [3:0]                    wstrb_q;
   logic [7:0]                    awaddr_q;
   logic                          append;
   logic [chcfg_pkg::STAT_W-1:0]  status;
   logic [chcfg_pkg::RES_MAX-1:0] result;
   logic                          data_read;

   // write channel: address and data taken in either order
   assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_idx  = awaddr_q[7:chcfg_pkg::IDX_LSB];
   assign rd_idx  = s_axi_araddr[7:chcfg_pkg::IDX_LSB];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= chcfg_pkg::RESP_OKAY;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h0000_0000;
         wstrb_q       <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            awaddr_q      <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_q      <= s_axi_wdata;
            wstrb_q      <= s_axi_wstrb;
         end
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == chcfg_pkg::IDX_CONTROL ||
                            (wr_idx >= chcfg_pkg::IDX_CH_FIRST &&
                             wr_idx <= chcfg_pkg::IDX_CH_LAST)) ?
                            chcfg_pkg::RESP_OKAY : chcfg_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // channel registers
   for (genvar i = 0; i < chcfg_pkg::NUM_CH; i++) begin : g_ch
      chcfg_chan_reg #(
         .RESET_VALUE (i == 0 ? chcfg_pkg::CH0_RESET : chcfg_pkg::CHN_RESET)
      ) u_reg (
         .clk_sys (clk_sys),
         .rst_n   (rst_n),
         .wr_en   (wr_fire && wr_idx == chcfg_pkg::IDX_CH_FIRST + 6'(i)),
         .wr_strb (wstrb_q[1:0]),
         .wr_data (wdata_q[15:0]),
         .value   (ch_q[i])
      );
      assign cfg[i] = chcfg_pkg::chcfg_route_t'(ch_q[i]);
      assign en[i]  = cfg[i].enable;
   end

   // control register: append flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         append <= 1'b0;
      end else if (wr_fire && wr_idx == chcfg_pkg::IDX_CONTROL &&
                   wstrb_q[0]) begin
         append <= wdata_q[chcfg_pkg::CTRL_APPEND_BIT];
      end
   end

   // next enabled channel above cur, wrapping; cur itself if sole one
   function automatic logic [3:0] next_ch(input logic [3:0]  cur,
                                          input logic [15:0] e);
      logic [3:0] k;
      logic [3:0] r;
      logic       found;
      r     = cur;
      found = 1'b0;
      for (int i = 1; i <= chcfg_pkg::NUM_CH; i++) begin
         k = cur + 4'(i);
         if (!found && e[k]) begin
            r     = k;
            found = 1'b1;
         end
      end
      return r;
   endfunction

   // sequencer pointer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_channel <= 4'h0;
         seq_active  <= 1'b0;
      end else begin
         seq_active <= |en;
         // a disabled pointer moves on at once, rather than stall
         if (conv_done || !en[cur_channel]) begin
            cur_channel <= next_ch(cur_channel, en);
         end
      end
   end

   // result and status capture; fresh flag set wins over read clear
   assign data_read = s_axi_arvalid && s_axi_arready &&
                      rd_idx == chcfg_pkg::IDX_DATA;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status <= 8'h00;
         result <= 24'h00_0000;
      end else begin
         if (data_read) begin
            status[chcfg_pkg::STATUS_FRESH_BIT] <= 1'b0;
         end
         if (conv_done) begin
            result      <= chcfg_pkg::RES_MAX'(conv_result);
            status[3:0] <= cur_channel;
            status[chcfg_pkg::STATUS_FRESH_BIT] <= 1'b1;
         end
      end
   end

   // source decode of one select field
   function automatic chcfg_pkg::chcfg_src_t src_of(input logic [4:0] s);
      if (s <= chcfg_pkg::SEL_PIN_LAST) begin
         return chcfg_pkg::SRC_PIN;
      end else if (s == chcfg_pkg::SEL_TEMP) begin
         return chcfg_pkg::SRC_TEMP;
      end else if (s == chcfg_pkg::SEL_AVSS) begin
         return chcfg_pkg::SRC_AVSS;
      end else if (s == chcfg_pkg::SEL_REF) begin
         return chcfg_pkg::SRC_REF;
      end else if (s == chcfg_pkg::SEL_DREG_P ||
                   s == chcfg_pkg::SEL_DREG_N) begin
         return chcfg_pkg::SRC_DREG;
      end else if (s == chcfg_pkg::SEL_TEST_P ||
                   s == chcfg_pkg::SEL_TEST_N) begin
         return chcfg_pkg::SRC_TEST;
      end else if (s >= chcfg_pkg::SEL_RSV_LO) begin
         return chcfg_pkg::SRC_RESV;
      end
      return chcfg_pkg::SRC_OTHER;
   endfunction

   // routing of the channel under conversion
   chcfg_pkg::chcfg_route_t sel;
   chcfg_pkg::chcfg_src_t   next_pos_src;
   chcfg_pkg::chcfg_src_t   next_neg_src;
   logic                    next_fault;
   always_comb begin
      sel          = cfg[cur_channel];
      next_pos_src = src_of(sel.positive_input_select);
      next_neg_src = src_of(sel.negative_input_select);
      // pair members must sit on the matching halves
      next_fault   = (next_pos_src == chcfg_pkg::SRC_RESV) ||
                     (next_neg_src == chcfg_pkg::SRC_RESV) ||
                     ((next_pos_src == chcfg_pkg::SRC_DREG ||
                       next_neg_src == chcfg_pkg::SRC_DREG) &&
                      !(sel.positive_input_select == chcfg_pkg::SEL_DREG_P &&
                        sel.negative_input_select == chcfg_pkg::SEL_DREG_N)) ||
                     ((next_pos_src == chcfg_pkg::SRC_TEST ||
                       next_neg_src == chcfg_pkg::SRC_TEST) &&
                      !(sel.positive_input_select == chcfg_pkg::SEL_TEST_P &&
                        sel.negative_input_select == chcfg_pkg::SEL_TEST_N)) ||
                     (sel.zero_pad != 2'h0);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cur_setup   <= 3'h0;
         cur_pos_sel <= 5'h00;
         cur_neg_sel <= 5'h01;
         cur_pos_src <= chcfg_pkg::SRC_PIN;
         cur_neg_src <= chcfg_pkg::SRC_PIN;
         route_fault <= 1'b0;
      end else begin
         cur_setup   <= sel.setup;
         cur_pos_sel <= sel.positive_input_select;
         cur_neg_sel <= sel.negative_input_select;
         cur_pos_src <= next_pos_src;
         cur_neg_src <= next_neg_src;
         route_fault <= next_fault;
      end
   end

   // read channel
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= chcfg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= chcfg_pkg::RESP_OKAY;
         s_axi_rdata   <= 32'h0000_0000;
         if (rd_idx == chcfg_pkg::IDX_STATUS) begin
            s_axi_rdata <= {24'h00_0000, status};
         end else if (rd_idx == chcfg_pkg::IDX_CONTROL) begin
            s_axi_rdata <= {31'h0000_0000, append};
         end else if (rd_idx == chcfg_pkg::IDX_DATA) begin
            s_axi_rdata <= append ? {result, status}
                                  : {8'h00, result};
         end else if (rd_idx >= chcfg_pkg::IDX_CH_FIRST &&
                      rd_idx <= chcfg_pkg::IDX_CH_LAST) begin
            s_axi_rdata <= {16'h0000,
                            ch_q[4'(rd_idx - chcfg_pkg::IDX_CH_FIRST)]};
         end else begin
            s_axi_rresp <= chcfg_pkg::RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // checks
   a_status_chan: assert property (conv_done |=>
      status[3:0] == $past(cur_channel))
      else $error("status channel not loaded");
   // the read clears the fresh bit, so compare against the byte it saw
   a_append_data: assert property (data_read && append &&
      !conv_done |=> s_axi_rdata[7:0] == $past(status))
      else $error("status not appended");
   a_setup_route: assert property (##1
      cur_setup == $past(sel.setup))
      else $error("setup not routed");
   a_pin_src: assert property (
      cur_pos_sel <= chcfg_pkg::SEL_PIN_LAST |->
      cur_pos_src == chcfg_pkg::SRC_PIN)
      else $error("pin code misdecoded");
   a_temp_src: assert property (
      cur_neg_sel == chcfg_pkg::SEL_TEMP |->
      cur_neg_src == chcfg_pkg::SRC_TEMP)
      else $error("temperature code misdecoded");
   a_pair_fault: assert property (
      cur_pos_sel == chcfg_pkg::SEL_DREG_P &&
      cur_neg_sel != chcfg_pkg::SEL_DREG_N |-> route_fault)
      else $error("unpaired regulator not flagged");
   a_resv_fault: assert property (
      cur_pos_sel >= chcfg_pkg::SEL_RSV_LO |-> route_fault)
      else $error("reserved code not flagged");
   a_seq_enabled: assert property (conv_done && (|en) |=>
      en[cur_channel] || !$past(en[next_ch(cur_channel, en)]))
      else $error("sequencer chose disabled channel");
   a_write_back: assert property (wr_fire &&
      wr_idx == chcfg_pkg::IDX_CH_FIRST && wstrb_q[1:0] == 2'h3
      |=> ch_q[0] == $past(wdata_q[15:0]))
      else $error("channel write lost");
   c_conv: cover property (conv_done);
   c_append: cover property (append && data_read);
   c_wrap: cover property (conv_done &&
      next_ch(cur_channel, en) < cur_channel);

endmodule

// >>> dv/chcfg_conv_model.sv
// converter stand-in: answers a start request with one result strobe
// assumes the bench pulses go for one cycle and waits for conv_done
`timescale 1ns/10ps
module chcfg_conv_model #(
   parameter int RESULT_W = 24
) (
   // clock and reset
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   // request from the bench
   input  wire logic                go,
   input  wire logic [7:0]          delay,
   input  wire logic [RESULT_W-1:0] res,
   // result strobe to the block
   output logic                     conv_done,
   output logic [RESULT_W-1:0]      conv_result
);
   logic                busy;
   logic [7:0]          cnt;
   logic [RESULT_W-1:0] held;

   // outside the strobe the result lines toggle, so a stale value never
   // looks like a fresh one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         busy        <= 1'b0;
         cnt         <= 8'h00;
         held        <= '0;
         conv_done   <= 1'b0;
         conv_result <= '0;
      end else if (go && !busy) begin
         busy        <= 1'b1;
         cnt         <= delay;
         held        <= res;
         conv_done   <= 1'b0;
         conv_result <= ~conv_result;
      end else if (busy && cnt == 8'h00) begin
         busy        <= 1'b0;
         conv_done   <= 1'b1;
         conv_result <= held;
      end else begin
         cnt         <= cnt - 8'h01;
         conv_done   <= 1'b0;
         conv_result <= ~conv_result;
      end
   end
endmodule

// >>> dv/tb.sv
// self-checking bench for the channel routing register bank
// assumes an axi4-lite master here and the converter model on the far side
`timescale 1ns/10ps
module tb;
   localparam logic [7:0] A_STAT = {chcfg_pkg::IDX_STATUS, 2'b00};
   localparam logic [7:0] A_CTRL = {chcfg_pkg::IDX_CONTROL, 2'b00};
   localparam logic [7:0] A_DATA = {chcfg_pkg::IDX_DATA, 2'b00};
   logic                  clk_sys = 1'b0;
   logic                  arst_n  = 1'b0;
   logic [7:0]            awaddr  = 8'h00;
   logic [7:0]            araddr  = 8'h00;
   logic [31:0]           wdata   = 32'h0;
   logic [3:0]            wstrb   = 4'h0;
   logic                  awvalid = 1'b0;
   logic                  wvalid  = 1'b0;
   logic                  bready  = 1'b0;
   logic                  arvalid = 1'b0;
   logic                  rready  = 1'b0;
   logic                  go      = 1'b0;
   logic [7:0]            delay   = 8'h00;
   logic [23:0]           res     = 24'h0;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic                  conv_done, route_fault, seq_active;
   logic [1:0]            bresp, rresp;
   logic [31:0]           rdata;
   logic [23:0]           conv_result;
   logic [3:0]            cur_channel;
   logic [2:0]            cur_setup;
   logic [4:0]            cur_pos_sel, cur_neg_sel;
   chcfg_pkg::chcfg_src_t cur_pos_src, cur_neg_src;
   int                    fails = 0;
   int                    samples_checked = 0;
   int                    cycles = 0;

   always #12.5 clk_sys = ~clk_sys;

   chcfg_top #(.RESULT_W(24)) uut (
      .clk_sys(clk_sys), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .conv_done(conv_done), .conv_result(conv_result),
      .cur_channel(cur_channel), .cur_setup(cur_setup),
      .cur_pos_sel(cur_pos_sel), .cur_neg_sel(cur_neg_sel),
      .cur_pos_src(cur_pos_src), .cur_neg_src(cur_neg_src),
      .route_fault(route_fault), .seq_active(seq_active));

   chcfg_conv_model #(.RESULT_W(24)) conv (
      .clk_sys(clk_sys), .rst_n(arst_n), .go(go), .delay(delay),
      .res(res), .conv_done(conv_done), .conv_result(conv_result));

   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 8000) begin
         fails++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
      @(posedge clk_sys);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      forever begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   task automatic wrv(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axw(a, d, 4'hF, r);
      chk({30'h0, r}, {30'h0, chcfg_pkg::RESP_OKAY});
   endtask

   task automatic rdv(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axr(a, d, r);
      chk(d, e);
      chk({30'h0, r}, {30'h0, chcfg_pkg::RESP_OKAY});
   endtask

   function automatic logic [7:0] ca(input int n);
      return {chcfg_pkg::IDX_CH_FIRST + 6'(n), 2'b00};
   endfunction

   function automatic logic [2:0] cls(input logic [4:0] c);
      if (c <= chcfg_pkg::SEL_PIN_LAST) return 3'h0;
      if (c == chcfg_pkg::SEL_TEMP) return 3'h1;
      if (c == chcfg_pkg::SEL_AVSS) return 3'h2;
      if (c == chcfg_pkg::SEL_REF) return 3'h3;
      if (c == chcfg_pkg::SEL_DREG_P || c == chcfg_pkg::SEL_DREG_N)
         return 3'h4;
      if (c == chcfg_pkg::SEL_TEST_P || c == chcfg_pkg::SEL_TEST_N)
         return 3'h5;
      return (c >= chcfg_pkg::SEL_RSV_LO) ? 3'h7 : 3'h6;
   endfunction

   // next enabled channel above c, wrapping past 15
   function automatic logic [3:0] nxt(input logic [15:0] en,
                                      input logic [3:0] c);
      for (int i = 1; i <= 16; i++)
         if (en[4'(c + i)]) return 4'(c + i);
      return c;
   endfunction

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [15:0] v;
      logic [4:0]  c, ng;
      logic [3:0]  ch;
      logic [23:0] rs;
      void'($urandom(32'hE830));
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      for (int n = 0; n < 16; n++)
         rdv(ca(n), n == 0 ? 32'h8001 : 32'h0001);
      $display("test reset values done");
      // host keeps bits 11:10 zero and reserved codes out of random data
      for (int k = 0; k < 20; k++) begin
         v = 16'($urandom) & 16'hF3FF;
         v[9:5] = 5'($urandom % 30);
         v[4:0] = 5'($urandom % 30);
         ch = 4'($urandom);
         wrv(ca(ch), {16'h0, v});
         rdv(ca(ch), {16'h0, v});
      end
      for (int n = 0; n < 16; n++)
         wrv(ca(n), n == 0 ? 32'h8000 : 32'h0001);
      axw(8'h7C, 32'hFFFF, 4'hF, r);
      chk({30'h0, r}, {30'h0, chcfg_pkg::RESP_SLVERR});
      axr(8'h7C, d, r);
      chk({d[29:0], r}, {30'h0, chcfg_pkg::RESP_SLVERR});
      $display("test readback done");
      // every select code; 30 and 31 on purpose, to see the fault flag
      for (int i = 0; i < 32; i++) begin
         c = 5'(i);
         ng = (c == chcfg_pkg::SEL_DREG_P || c == chcfg_pkg::SEL_TEST_P)
              ? c + 5'h01 : 5'h01;
         wrv(ca(0), {16'h0, 1'b1, c[2:0], 2'b00, c, ng});
         repeat (4) @(posedge clk_sys);
         chk({cur_channel, cur_setup, cur_pos_sel, cur_neg_sel, cur_pos_src,
              cur_neg_src, route_fault, seq_active},
             {4'h0, c[2:0], c, ng, cls(c), cls(ng),
              c == 5'h1B || c == 5'h1D || c >= 5'h1E,
              1'b1});
      end
      // bit 10 of the zero pad set on purpose: the block must raise its fault flag
      wrv(ca(0), 32'h8401);
      repeat (4) @(posedge clk_sys);
      chk({31'h0, route_fault}, 32'h1);
      $display("test routing codes done");
      wrv(ca(3), 32'h8001);
      wrv(ca(7), 32'h8001);
      wrv(ca(12), 32'h8001);
      wrv(ca(0), 32'h0001);
      repeat (20) @(posedge clk_sys);
      ch = nxt(16'h1088, 4'hF);
      for (int k = 0; k < 6; k++) begin
         chk({28'h0, cur_channel}, {28'h0, ch});
         rs = 24'($urandom);
         wrv(A_CTRL, 32'(k % 2));
         @(posedge clk_sys);
         res   <= rs;
         delay <= 8'($urandom % 6);
         go    <= 1'b1;
         @(posedge clk_sys);
         go <= 1'b0;
         do @(posedge clk_sys); while (conv_done !== 1'b1);
         repeat (3) @(posedge clk_sys);
         rdv(A_STAT, {24'h0, 4'h8, ch});
         rdv(A_DATA, k % 2 ? {rs, 4'h8, ch} : {8'h00, rs});
         rdv(A_STAT, {28'h0, ch});
         ch = nxt(16'h1088, ch);
      end
      $display("test sequence and status done");
      conclude();
   end
endmodule
